// File: mmd_pkg.sv
`default_nettype none
package mmd_pkg;
	// ------------------------------------------------------------
	// instruction field positions
	// ------------------------------------------------------------
	localparam int A_HI = 31;
	localparam int A_LO = 27;
	localparam int B_HI = 26;
	localparam int B_LO = 22;
	localparam int C_HI = 21;
	localparam int C_LO = 17;
	localparam int IMM_HI = 21;
	localparam int IMM_LO = 6;
	localparam int OPX_HI = 16;
	localparam int OPX_LO = 11;
	localparam int OP_HI = 5;
	localparam int OP_LO = 0;
	// ------------------------------------------------------------
	// opcodes
	// ------------------------------------------------------------
	localparam logic [5:0] OP_RTYPE = 6'h3a;
	localparam logic [5:0] OP_LOAD_WORD = 6'h17;
	localparam logic [5:0] OP_LOAD_WORD_IO = 6'h37;
	localparam logic [5:0] OP_MUL_IMM = 6'h24;
	localparam logic [5:0] OP_OR_HIGH = 6'h34;
	localparam logic [5:0] OP_OR_LOW = 6'h14;
	localparam logic [5:0] OP_ADD_IMM = 6'h04;
	localparam logic [5:0] OPX_HIGH_SS = 6'h1f;
	localparam logic [5:0] OPX_HIGH_UU = 6'h07;
	localparam logic [5:0] OPX_HIGH_SU = 6'h17;
	localparam logic [5:0] OPX_MUL_LOW = 6'h2e;
	localparam logic [5:0] OPX_ADD = 6'h30;
	// ------------------------------------------------------------
	// reset values and zero fill
	// ------------------------------------------------------------
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [4:0] RST_INDEX = 5'h00;
	localparam logic [15:0] ZERO_HALF = 16'h0000;

	typedef struct packed {
		logic wb_valid;
		logic [4:0] wb_index;
		logic [31:0] wb_data;
		logic unimpl_exc;
		logic load_req;
		logic load_bypass;
		logic [4:0] load_index;
		logic [31:0] load_addr;
	} dp_state_t;
endpackage
`default_nettype wire

// File: mul_if.sv
`timescale 1ns/10ps
`default_nettype none
interface mul_if;
	logic signed [32:0] op_a;
	logic signed [32:0] op_b;
	logic [63:0] product;
	modport host (output op_a, output op_b, input product);
	modport unit (input op_a, input op_b, output product);
endinterface
`default_nettype wire

// File: mul_unit.sv
`timescale 1ns/10ps
`default_nettype none
module mul_unit (
	mul_if.unit m
);
	// operands arrive with an extension bit that picks signed or unsigned
	logic signed [65:0] full;

	assign full = m.op_a * m.op_b;
	assign m.product = full[63:0];
endmodule
`default_nettype wire

// File: multiply_move_datapath.sv
`timescale 1ns/10ps
`default_nettype none
module multiply_move_datapath (
	// clock, reset, enable
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic ce,
	// issue from decode
	input wire logic instr_valid,
	input wire logic [31:0] instr_word,
	input wire logic [31:0] src_a_value,
	input wire logic [31:0] src_b_value,
	input wire logic mul_hw_present,
	// register file write back
	output logic wb_valid,
	output logic [4:0] wb_index,
	output logic [31:0] wb_data,
	output logic unimpl_exc,
	// word load request
	output logic load_req,
	output logic load_bypass,
	output logic [4:0] load_index,
	output logic [31:0] load_addr
);
	import mmd_pkg::*;

	mmd_pkg::dp_state_t st_reg;
	mmd_pkg::dp_state_t st_next;
	mul_if mi ();
	logic [5:0] opc;
	logic [5:0] opx;
	logic [4:0] fa;
	logic [4:0] fb;
	logic [4:0] fc;
	logic [15:0] imm;
	logic [31:0] sext_imm;
	logic [31:0] a_val;
	logic [31:0] b_val;
	logic mul_op;

	mul_unit u_mul (
		.m(mi.unit)
	);

	// ------------------------------------------------------------
	// field decode
	// ------------------------------------------------------------
	assign opc = instr_word[OP_HI:OP_LO];
	assign fa = instr_word[A_HI:A_LO];
	assign fb = instr_word[B_HI:B_LO];
	assign fc = instr_word[C_HI:C_LO];
	assign opx = instr_word[OPX_HI:OPX_LO];
	assign imm = instr_word[IMM_HI:IMM_LO];
	assign sext_imm = {{16{imm[15]}}, imm};
	// index zero always reads as zero, which the pseudo moves rely on
	assign a_val = (fa == 5'h00) ? RST_WORD : src_a_value;
	assign b_val = (fb == 5'h00) ? RST_WORD : src_b_value;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.wb_valid = 1'b0;
		st_next.unimpl_exc = 1'b0;
		st_next.load_req = 1'b0;
		mul_op = 1'b0;
		mi.op_a = {1'b0, a_val};
		mi.op_b = {1'b0, b_val};
		if (instr_valid) begin
			case (opc)
				OP_RTYPE: begin
					st_next.wb_index = fc;
					case (opx)
						OPX_ADD: begin
							st_next.wb_valid = 1'b1;
							st_next.wb_data = a_val + b_val;
						end
						OPX_MUL_LOW: begin
							mul_op = 1'b1;
							st_next.wb_data = mi.product[31:0];
						end
						OPX_HIGH_SS: begin
							mul_op = 1'b1;
							mi.op_a = {a_val[31], a_val};
							mi.op_b = {b_val[31], b_val};
							st_next.wb_data = mi.product[63:32];
						end
						OPX_HIGH_UU: begin
							mul_op = 1'b1;
							st_next.wb_data = mi.product[63:32];
						end
						OPX_HIGH_SU: begin
							mul_op = 1'b1;
							mi.op_a = {a_val[31], a_val};
							st_next.wb_data = mi.product[63:32];
						end
						default: begin
							st_next.wb_valid = 1'b0;
						end
					endcase
				end
				OP_MUL_IMM: begin
					mul_op = 1'b1;
					st_next.wb_index = fb;
					mi.op_b = {1'b0, sext_imm};
					st_next.wb_data = mi.product[31:0];
				end
				OP_OR_HIGH: begin
					st_next.wb_valid = 1'b1;
					st_next.wb_index = fb;
					st_next.wb_data = a_val | {imm, ZERO_HALF};
				end
				OP_OR_LOW: begin
					st_next.wb_valid = 1'b1;
					st_next.wb_index = fb;
					st_next.wb_data = a_val | {ZERO_HALF, imm};
				end
				OP_ADD_IMM: begin
					st_next.wb_valid = 1'b1;
					st_next.wb_index = fb;
					st_next.wb_data = a_val + sext_imm;
				end
				OP_LOAD_WORD, OP_LOAD_WORD_IO: begin
					st_next.load_req = 1'b1;
					st_next.load_bypass = (opc == OP_LOAD_WORD_IO);
					st_next.load_index = fb;
					st_next.load_addr = a_val + sext_imm;
				end
				default: begin
					st_next.wb_valid = 1'b0;
				end
			endcase
			if (mul_op) begin
				st_next.wb_valid = mul_hw_present;
				st_next.unimpl_exc = !mul_hw_present;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st_reg <= '{wb_valid: 1'b0, wb_index: RST_INDEX, wb_data: RST_WORD,
				unimpl_exc: 1'b0, load_req: 1'b0, load_bypass: 1'b0,
				load_index: RST_INDEX, load_addr: RST_WORD};
		end else if (ce) begin
			st_reg <= st_next;
		end
	end

	assign wb_valid = st_reg.wb_valid;
	assign wb_index = st_reg.wb_index;
	assign wb_data = st_reg.wb_data;
	assign unimpl_exc = st_reg.unimpl_exc;
	assign load_req = st_reg.load_req;
	assign load_bypass = st_reg.load_bypass;
	assign load_index = st_reg.load_index;
	assign load_addr = st_reg.load_addr;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	logic go;
	logic hw_go;
	logic is_r;
	logic signed [63:0] ss_prod;
	logic [63:0] uu_prod;
	logic [63:0] su_prod;

	assign go = ce && instr_valid;
	assign hw_go = go && mul_hw_present;
	assign is_r = (opc == OP_RTYPE);
	// reference products are formed at full 64-bit width so no high bits are lost
	assign ss_prod = {{32{a_val[31]}}, a_val} * {{32{b_val[31]}}, b_val};
	assign uu_prod = {32'h0000_0000, a_val} * {32'h0000_0000, b_val};
	assign su_prod = {{32{a_val[31]}}, a_val} * {32'h0000_0000, b_val};

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	chk_load_decode: assert property (
		go && (opc == OP_LOAD_WORD || opc == OP_LOAD_WORD_IO)
		|=> load_req && load_bypass == $past(opc[5]) && !wb_valid)
		else $error("word load not decoded");
	chk_copy_move: assert property (
		go && is_r && opx == OPX_ADD && fb == 5'h00
		|=> wb_valid && wb_data == $past(a_val) && wb_index == $past(fc))
		else $error("register copy wrong");
	chk_upper_load: assert property (
		go && opc == OP_OR_HIGH && fa == 5'h00
		|=> wb_valid && wb_data == {$past(imm), 16'h0000} && wb_index == $past(fb))
		else $error("upper half load wrong");
	chk_signed_const: assert property (
		go && opc == OP_ADD_IMM && fa == 5'h00
		|=> wb_valid && wb_data == {{16{$past(imm[15])}}, $past(imm)})
		else $error("signed constant load wrong");
	chk_unsigned_const: assert property (
		go && opc == OP_OR_LOW && fa == 5'h00
		|=> wb_valid && wb_data == {16'h0000, $past(imm)})
		else $error("unsigned constant load wrong");
	chk_low_product: assert property (
		hw_go && is_r && opx == OPX_MUL_LOW
		|=> wb_valid && wb_data == $past(uu_prod[31:0]))
		else $error("low product wrong");
	chk_no_mul_hw: assert property (
		go && !mul_hw_present && (opc == OP_MUL_IMM || (is_r
		&& (opx == OPX_MUL_LOW || opx == OPX_HIGH_SS || opx == OPX_HIGH_UU
		|| opx == OPX_HIGH_SU))) |=> unimpl_exc && !wb_valid)
		else $error("missing exception");
	chk_imm_product: assert property (
		hw_go && opc == OP_MUL_IMM
		|=> wb_valid && wb_index == $past(fb)
		&& wb_data == 32'($past(a_val) * $past(sext_imm)))
		else $error("immediate product wrong");
	chk_high_ss: assert property (
		hw_go && is_r && opx == OPX_HIGH_SS
		|=> wb_data == $past(ss_prod[63:32]))
		else $error("signed high product wrong");
	chk_carry_flag: assert property (
		hw_go && is_r && opx == OPX_HIGH_UU
		|=> (wb_data != 32'h0000_0000) == ($past(uu_prod[63:32]) != 32'h0000_0000))
		else $error("carry detect broken");
	chk_overflow_flag: assert property (
		hw_go && is_r && opx == OPX_HIGH_SS
		|=> (32'(wb_data + {31'h0, $past(ss_prod[31])}) == 32'h0000_0000)
		== ($past(ss_prod) == 64'($signed($past(ss_prod[31:0])))))
		else $error("overflow detect broken");
	chk_high_uu: assert property (
		hw_go && is_r && opx == OPX_HIGH_UU
		|=> wb_data == $past(uu_prod[63:32]))
		else $error("unsigned high product wrong");
	chk_high_su: assert property (
		hw_go && is_r && opx == OPX_HIGH_SU
		|=> wb_data == $past(su_prod[63:32]))
		else $error("mixed high product wrong");
endmodule
`default_nettype wire

// File: multiply_move_datapath_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module multiply_move_datapath_tb_top;
	import mmd_pkg::*;
	logic clk_sys, sys_rst, ce, instr_valid, mul_hw_present;
	logic [31:0] instr_word, src_a_value, src_b_value, wb_data, load_addr;
	logic wb_valid, unimpl_exc, load_req, load_bypass;
	logic [4:0] wb_index, load_index;
	int err_total = 0;
	int total_checks = 0;
	int cycles = 0;
	multiply_move_datapath multiply_move_datapath_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.ce(ce), .instr_valid(instr_valid), .instr_word(instr_word),
		.src_a_value(src_a_value), .src_b_value(src_b_value),
		.mul_hw_present(mul_hw_present), .wb_valid(wb_valid), .wb_index(wb_index),
		.wb_data(wb_data), .unimpl_exc(unimpl_exc), .load_req(load_req),
		.load_bypass(load_bypass), .load_index(load_index), .load_addr(load_addr));
	// ------------------------------------------------------------
	// clock, timeout, helpers
	// ------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			err_total++;
			print_verdict();
		end
	end
	function automatic logic [31:0] rw(input logic [5:0] opx);
		return {5'h07, 5'h08, 5'h09, opx, 5'h00, 6'h3a};
	endfunction
	function automatic logic [31:0] iw(input logic [4:0] a, b, input logic [15:0] imm,
		input logic [5:0] op);
		return {a, b, imm, op};
	endfunction
	task automatic check(input string what, input logic [31:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one instruction, outputs settled in the answer cycle on return
	task automatic issue(input logic [31:0] w, a, b);
		@(posedge clk_sys);
		#1;
		instr_valid = 1'b1;
		instr_word = w;
		src_a_value = a;
		src_b_value = b;
		@(posedge clk_sys);
		#1;
		instr_valid = 1'b0;
	endtask
	task automatic wb(input string what, input logic [4:0] idx, input logic [31:0] d);
		check(what, {31'h0, wb_valid}, 32'h1);
		check(what, {31'h0, unimpl_exc}, 32'h0);
		check(what, {27'h0, wb_index}, {27'h0, idx});
		check(what, wb_data, d);
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_mul(input logic [31:0] a, b);
		logic [63:0] ss, uu, su;
		logic [31:0] lo;
		ss = {{32{a[31]}}, a} * {{32{b[31]}}, b};
		uu = {32'h0, a} * {32'h0, b};
		su = {{32{a[31]}}, a} * {32'h0, b};
		issue(rw(OPX_MUL_LOW), a, b);
		wb("mul", 5'h09, ss[31:0]);
		lo = wb_data;
		issue(rw(6'h1f), a, b);
		wb("mulss", 5'h09, ss[63:32]);
		check("fits", {31'h0, (wb_data + {31'h0, lo[31]}) == 32'h0},
			{31'h0, ss[63:31] == {33{ss[31]}}});
		issue(rw(6'h07), a, b);
		wb("muluu", 5'h09, uu[63:32]);
		check("carry", {31'h0, wb_data != 32'h0}, {31'h0, uu[63:32] != 32'h0});
		issue(rw(6'h17), a, b);
		wb("mulsu", 5'h09, su[63:32]);
		$display("test mul done");
	endtask
	task automatic t_muli;
		issue(iw(5'h07, 5'h0b, 16'hff9c, 6'h24), 32'h0001_0003, 32'h5555_aaaa);
		wb("muli", 5'h0b, 32'h0001_0003 * 32'hffff_ff9c);
		$display("test muli done");
	endtask
	task automatic t_moves;
		issue({5'h07, 5'h00, 5'h0c, OPX_ADD, 5'h00, 6'h3a}, 32'h89ab_cdef, 32'h1357_9bdf);
		wb("mov", 5'h0c, 32'h89ab_cdef);
		issue(iw(5'h00, 5'h0d, 16'hffff, 6'h34), 32'h2468_ace0, 32'h0);
		wb("movhi", 5'h0d, 32'hffff_0000);
		issue(iw(5'h00, 5'h0e, 16'h8000, OP_ADD_IMM), 32'h2468_ace0, 32'h0);
		wb("movi", 5'h0e, 32'hffff_8000);
		issue(iw(5'h00, 5'h0f, 16'hffff, 6'h14), 32'h2468_ace0, 32'h0);
		wb("movui", 5'h0f, 32'h0000_ffff);
		issue(iw(5'h00, 5'h06, 16'h1235, 6'h34), 32'h2468_ace0, 32'h0);
		wb("movia hi", 5'h06, 32'h1235_0000);
		issue(iw(5'h06, 5'h06, 16'h8765, OP_ADD_IMM), 32'h1235_0000, 32'h0);
		wb("movia lo", 5'h06, 32'h1234_8765);
		$display("test moves done");
	endtask
	task automatic ld(input logic [31:0] w, input logic byp, input logic [4:0] idx,
		input logic [31:0] addr);
		issue(w, 32'h0000_1000, 32'h0);
		check("load_req", {31'h0, load_req}, 32'h1);
		check("load_bypass", {31'h0, load_bypass}, {31'h0, byp});
		check("load_index", {27'h0, load_index}, {27'h0, idx});
		check("load_addr", load_addr, addr);
	endtask
	task automatic t_load;
		ld(iw(5'h03, 5'h11, 16'hfffc, 6'h17), 1'b0, 5'h11, 32'h0000_0ffc);
		ld(iw(5'h03, 5'h12, 16'h0010, 6'h37), 1'b1, 5'h12, 32'h0000_1010);
		@(posedge clk_sys);
		#1;
		check("load_req end", {31'h0, load_req}, 32'h0);
		$display("test load done");
	endtask
	task automatic t_refuse;
		issue(rw(6'h01), 32'h0000_0001, 32'h0000_0002);
		check("refuse opx", {29'h0, wb_valid, unimpl_exc, load_req}, 32'h0);
		issue(iw(5'h01, 5'h02, 16'h1234, 6'h3f), 32'h0000_0001, 32'h0000_0002);
		check("refuse op", {29'h0, wb_valid, unimpl_exc, load_req}, 32'h0);
		$display("test refuse done");
	endtask
	task automatic t_freeze;
		issue(iw(5'h00, 5'h10, 16'h0042, OP_OR_LOW), 32'h0, 32'h0);
		wb("freeze pre", 5'h10, 32'h0000_0042);
		ce = 1'b0;
		issue(iw(5'h00, 5'h11, 16'h0077, OP_OR_LOW), 32'h0, 32'h0);
		wb("freeze hold", 5'h10, 32'h0000_0042);
		ce = 1'b1;
		@(posedge clk_sys);
		#1;
		check("freeze end", {31'h0, wb_valid}, 32'h0);
		check("freeze data", wb_data, 32'h0000_0042);
		$display("test freeze done");
	endtask
	task automatic t_nohw;
		logic [31:0] w [5];
		w = '{rw(OPX_MUL_LOW), rw(6'h1f), rw(6'h07), rw(6'h17),
			iw(5'h07, 5'h0b, 16'h0005, 6'h24)};
		@(posedge clk_sys);
		#1;
		mul_hw_present = 1'b0;
		foreach (w[i]) begin
			issue(w[i], 32'h0000_0007, 32'h0000_0009);
			check("unimpl_exc", {31'h0, unimpl_exc}, 32'h1);
			check("wb_valid", {31'h0, wb_valid}, 32'h0);
		end
		$display("test nohw done");
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		sys_rst = 1'b1;
		ce = 1'b1;
		instr_valid = 1'b0;
		instr_word = 32'h0;
		src_a_value = 32'h0;
		src_b_value = 32'h0;
		mul_hw_present = 1'b1;
		repeat (16) @(posedge clk_sys);
		#1;
		sys_rst = 1'b0;
		check("rst wb_data", wb_data, 32'h0);
		check("rst pulses", {29'h0, wb_valid, unimpl_exc, load_req}, 32'h0);
		check("rst load", {load_addr[26:0], load_index}, 32'h0);
		t_mul(32'hffff_fffe, 32'h8000_0003);
		t_mul(32'h0000_1234, 32'hffff_fff0);
		t_mul(32'h0000_1234, 32'h0000_5678);
		t_muli();
		t_moves();
		t_load();
		t_refuse();
		t_freeze();
		t_nohw();
		print_verdict();
	end
endmodule
`default_nettype wire
